// file: drs_run_seq.v
// run/sleep/restart/braking sequencer with an Avalon-MM register slave
// Overview of operation
// - set frequency under a non-zero lower limit: units 0 runs at the limit, 1 stops, 2 sleeps.
// - for stop or sleep the tens digit picks coast (0) or ramp down (1).
// - after a below-limit stop the drive restarts alone once set frequency exceeds the limit.
// - with sleep chosen the drive sleeps once running frequency has stayed under the limit for the whole sleep delay.
// - it wakes only if set frequency stays above the limit for the whole wake delay.
// - the wake delay matters only when the units digit selects sleep.
// - with auto restart on, the drive starts alone after power-up once the wait and start conditions hold.
// - the restart wait is used only while auto restart is enabled.
// - after a run command output is held off for the start delay.
// - open loop at zero frequency outputs nothing, voltage, or the stop DC braking current per selection.
// - in direct start mode a non-zero start hold gives short-circuit braking before starting.
// - a non-zero stop hold gives short-circuit braking after a ramp-down stop, followed by DC braking.
// - the short-circuit braking current is limited to 0 to 150 percent.
// - before DC braking after stop output is blocked for the demagnetization wait.
`include "drs_map.vh"
`default_nettype none
module drs_run_seq #(
   parameter TICK_CYCLES = `DRS_TICK_CYCLES,
   parameter FW          = 16
) (
   input  wire          mclk,
   input  wire          rst_n,
   input  wire [7:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output reg  [31:0]   avs_readdata,
   output reg           avs_waitrequest,
   input  wire [FW-1:0] run_freq,
   input  wire          stop_reached_pin,
   input  wire          dc_bus_ok_pin,
   output reg           drv_enable,
   output reg           ramp_down,
   output reg           short_brake,
   output reg           dc_brake,
   output reg  [FW-1:0] freq_ref,
   output reg  [10:0]   sb_current,
   output reg           run_active
);
   localparam S_IDLE  = 11'h001;
   localparam S_RWAIT = 11'h002;
   localparam S_SDLY  = 11'h004;
   localparam S_SBST  = 11'h008;
   localparam S_RUN   = 11'h010;
   localparam S_STOP  = 11'h020;
   localparam S_SBSP  = 11'h040;
   localparam S_DEMAG = 11'h080;
   localparam S_DCBR  = 11'h100;
   localparam S_BLSP  = 11'h200;
   localparam S_SLEEP = 11'h400;

   localparam K_CMD = 2'h0;
   localparam K_BL  = 2'h1;
   localparam K_SLP = 2'h2;

   // configuration
   reg  [1:0]    ctrl_reg;
   reg  [7:0]    action_reg;
   reg  [15:0]   wake_dly_reg;
   reg           auto_rst_reg;
   reg  [15:0]   rst_wait_reg;
   reg  [15:0]   start_dly_reg;
   reg  [1:0]    zero_sel_reg;
   reg  [10:0]   sb_curr_reg;
   reg  [15:0]   sb_start_reg;
   reg  [15:0]   sb_stop_reg;
   reg  [1:0]    start_mode_reg;
   reg  [15:0]   dc_time_reg;
   reg  [15:0]   demag_reg;
   reg  [FW-1:0] set_freq_reg;
   reg  [FW-1:0] low_limit_reg;
   reg  [15:0]   sleep_dly_reg;

   // sequencer
   reg  [10:0]   state_reg;
   reg  [10:0]   state_next;
   reg  [10:0]   prev_state_reg;
   reg  [1:0]    kind_reg;
   reg  [1:0]    kind_next;
   reg           powerup_reg;
   reg           stop_s1_reg;
   reg           stop_s2_reg;
   reg           bus_s1_reg;
   reg           bus_s2_reg;
   reg  [15:0]   phase_preset;
   reg  [10:0]   dest_state;

   // bus
   reg  [31:0]   rd_mux;
   reg  [31:0]   bmask;
   wire [31:0]   wmerge;
   wire          wr_commit;
   wire [7:0]    waddr;

   wire          tick;
   wire          phase_raw;
   wire          phase_done;
   wire          wake_done;
   wire          sleep_done;

   wire          run_cmd   = ctrl_reg[`DRS_CTRL_RUN];
   wire          open_loop = ctrl_reg[`DRS_CTRL_OPEN_LOOP];
   wire [3:0]    act_units = action_reg[`DRS_ACT_UNITS_LSB +: 4];
   wire [3:0]    act_tens  = action_reg[`DRS_ACT_TENS_LSB +: 4];
   wire          coast     = (act_tens != `DRS_TENS_RAMP);
   wire          coast_now = coast && (kind_reg != K_CMD);
   // outputs belong to the next state, so they follow the stop kind being entered
   wire          coast_nx  = coast && (kind_next != K_CMD);
   wire          lim_valid = (low_limit_reg != {FW{1'b0}});
   wire          below_set = lim_valid && (set_freq_reg < low_limit_reg);
   wire          above_set = lim_valid && (set_freq_reg > low_limit_reg);
   wire          below_run = lim_valid && (run_freq < low_limit_reg);
   wire          sleep_sel = (act_units == `DRS_ACT_SLEEP);
   wire          auto_fire = state_reg[1] && phase_done && bus_s2_reg && auto_rst_reg;

   drs_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .tick   (tick)
   );

   // phase timer restarts on every state change
   drs_timer #(
      .W      (16)
   ) u_phase (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .tick   (tick),
      .en     (state_reg == prev_state_reg),
      .preset (phase_preset),
      .done   (phase_raw)
   );

   // a done left over from the previous state must not end the new one
   assign phase_done = (phase_raw && (state_reg == prev_state_reg)) ||
                       (phase_preset == 16'h0000);

   drs_timer #(
      .W      (16)
   ) u_wake (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .tick   (tick),
      .en     (state_reg[10] && above_set),
      .preset (wake_dly_reg),
      .done   (wake_done)
   );

   drs_timer #(
      .W      (16)
   ) u_sleep (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .tick   (tick),
      .en     (state_reg[4] && sleep_sel && below_run),
      .preset (sleep_dly_reg),
      .done   (sleep_done)
   );

   // ---------------- Avalon-MM slave ----------------
   // one wait cycle per access; write lands on the edge that sees waitrequest low
   assign wr_commit = avs_write && !avs_waitrequest;
   assign waddr     = {avs_address[7:2], 2'b00};
   assign wmerge    = (rd_mux & ~bmask) | (avs_writedata & bmask);

   always @* begin
      bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      case (waddr)
         `DRS_OFS_CTRL:       rd_mux = {30'h0000_0000, ctrl_reg};
         `DRS_OFS_ACTION:     rd_mux = {24'h00_0000, action_reg};
         `DRS_OFS_WAKE_DLY:   rd_mux = {16'h0000, wake_dly_reg};
         `DRS_OFS_AUTO_RST:   rd_mux = {31'h0000_0000, auto_rst_reg};
         `DRS_OFS_RST_WAIT:   rd_mux = {16'h0000, rst_wait_reg};
         `DRS_OFS_START_DLY:  rd_mux = {16'h0000, start_dly_reg};
         `DRS_OFS_ZERO_SEL:   rd_mux = {30'h0000_0000, zero_sel_reg};
         `DRS_OFS_SB_CURR:    rd_mux = {21'h00_0000, sb_curr_reg};
         `DRS_OFS_SB_START:   rd_mux = {16'h0000, sb_start_reg};
         `DRS_OFS_SB_STOP:    rd_mux = {16'h0000, sb_stop_reg};
         `DRS_OFS_START_MODE: rd_mux = {30'h0000_0000, start_mode_reg};
         `DRS_OFS_DC_TIME:    rd_mux = {16'h0000, dc_time_reg};
         `DRS_OFS_DEMAG:      rd_mux = {16'h0000, demag_reg};
         `DRS_OFS_SET_FREQ:   rd_mux = {{(32-FW){1'b0}}, set_freq_reg};
         `DRS_OFS_LOW_LIMIT:  rd_mux = {{(32-FW){1'b0}}, low_limit_reg};
         `DRS_OFS_SLEEP_DLY:  rd_mux = {16'h0000, sleep_dly_reg};
         `DRS_OFS_STATUS:     rd_mux = {13'h0000, kind_reg, powerup_reg, state_reg,
                                        run_active, dc_brake, short_brake, ramp_down, drv_enable};
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg       <= `DRS_RST_CTRL;
         action_reg     <= `DRS_RST_ACTION;
         wake_dly_reg   <= `DRS_RST_WAKE_DLY;
         auto_rst_reg   <= `DRS_RST_AUTO_RST;
         rst_wait_reg   <= `DRS_RST_RST_WAIT;
         start_dly_reg  <= `DRS_RST_START_DLY;
         zero_sel_reg   <= `DRS_RST_ZERO_SEL;
         sb_curr_reg    <= `DRS_RST_SB_CURR;
         sb_start_reg   <= `DRS_RST_SB_START;
         sb_stop_reg    <= `DRS_RST_SB_STOP;
         start_mode_reg <= `DRS_RST_START_MODE;
         dc_time_reg    <= `DRS_RST_DC_TIME;
         demag_reg      <= `DRS_RST_DEMAG;
         set_freq_reg   <= `DRS_RST_SET_FREQ;
         low_limit_reg  <= `DRS_RST_LOW_LIMIT;
         sleep_dly_reg  <= `DRS_RST_SLEEP_DLY;
      end else begin
         if (wr_commit) begin
            case (waddr)
               `DRS_OFS_CTRL:       ctrl_reg       <= wmerge[1:0];
               `DRS_OFS_ACTION:     action_reg     <= wmerge[7:0];
               `DRS_OFS_WAKE_DLY:   wake_dly_reg   <= wmerge[15:0];
               `DRS_OFS_AUTO_RST:   auto_rst_reg   <= wmerge[0];
               `DRS_OFS_RST_WAIT:   rst_wait_reg   <= wmerge[15:0];
               `DRS_OFS_START_DLY:  start_dly_reg  <= wmerge[15:0];
               `DRS_OFS_ZERO_SEL:   zero_sel_reg   <= wmerge[1:0];
               `DRS_OFS_SB_CURR:    sb_curr_reg    <= (wmerge[15:0] > {5'h00, `DRS_SB_CURR_MAX}) ?
                                                      `DRS_SB_CURR_MAX : wmerge[10:0];
               `DRS_OFS_SB_START:   sb_start_reg   <= wmerge[15:0];
               `DRS_OFS_SB_STOP:    sb_stop_reg    <= wmerge[15:0];
               `DRS_OFS_START_MODE: start_mode_reg <= wmerge[1:0];
               `DRS_OFS_DC_TIME:    dc_time_reg    <= wmerge[15:0];
               `DRS_OFS_DEMAG:      demag_reg      <= wmerge[15:0];
               `DRS_OFS_SET_FREQ:   set_freq_reg   <= wmerge[FW-1:0];
               `DRS_OFS_LOW_LIMIT:  low_limit_reg  <= wmerge[FW-1:0];
               `DRS_OFS_SLEEP_DLY:  sleep_dly_reg  <= wmerge[15:0];
               default:             ;
            endcase
         end
         // auto restart latches the run command; placed last so it beats a clearing write
         if (auto_fire)
            ctrl_reg[`DRS_CTRL_RUN] <= 1'b1;
      end
   end

   // ---------------- pin synchronisers ----------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         stop_s1_reg <= 1'b0;
         stop_s2_reg <= 1'b0;
         bus_s1_reg  <= 1'b0;
         bus_s2_reg  <= 1'b0;
      end else begin
         stop_s1_reg <= stop_reached_pin;
         stop_s2_reg <= stop_s1_reg;
         bus_s1_reg  <= dc_bus_ok_pin;
         bus_s2_reg  <= bus_s1_reg;
      end
   end

   // ---------------- sequencer ----------------
   always @* begin
      case (state_reg)
         S_RWAIT: phase_preset = rst_wait_reg;
         S_SDLY:  phase_preset = start_dly_reg;
         S_SBST:  phase_preset = sb_start_reg;
         S_SBSP:  phase_preset = sb_stop_reg;
         S_DEMAG: phase_preset = demag_reg;
         S_DCBR:  phase_preset = dc_time_reg;
         default: phase_preset = 16'h0000;
      endcase
      case (kind_reg)
         K_BL:    dest_state = S_BLSP;
         K_SLP:   dest_state = S_SLEEP;
         default: dest_state = S_IDLE;
      endcase
   end

   always @* begin
      state_next = state_reg;
      kind_next  = kind_reg;
      case (state_reg)
         S_IDLE: begin
            if (powerup_reg && auto_rst_reg)
               state_next = S_RWAIT;
            else if (run_cmd)
               state_next = S_SDLY;
         end
         S_RWAIT: begin
            if (!auto_rst_reg)
               state_next = S_IDLE;
            else if (phase_done && bus_s2_reg)
               state_next = S_SDLY;
         end
         S_SDLY: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (phase_done)
               state_next = (start_mode_reg == `DRS_MODE_DIRECT) ? S_SBST : S_RUN;
         end
         S_SBST: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (phase_done)
               state_next = S_RUN;
         end
         S_RUN: begin
            if (!run_cmd) begin
               kind_next  = K_CMD;
               state_next = S_STOP;
            end else if (below_set && act_units == `DRS_ACT_STOP) begin
               kind_next  = K_BL;
               state_next = S_STOP;
            end else if (sleep_done) begin
               kind_next  = K_SLP;
               state_next = S_STOP;
            end
         end
         S_STOP: begin
            if (coast_now)
               state_next = dest_state;
            else if (stop_s2_reg)
               state_next = S_SBSP;
         end
         S_SBSP: begin
            if (phase_done)
               state_next = S_DEMAG;
         end
         S_DEMAG: begin
            if (phase_done)
               state_next = S_DCBR;
         end
         S_DCBR: begin
            if (phase_done)
               state_next = dest_state;
         end
         S_BLSP: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (above_set)
               state_next = S_SDLY;
         end
         S_SLEEP: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (wake_done)
               state_next = S_SDLY;
         end
         default: state_next = S_IDLE;
      endcase
   end

   // output values for the next state, all registered
   reg  [FW-1:0] fref_next;
   reg           en_next;
   reg           dc_next;
   reg           zero_out;

   always @* begin
      fref_next = {FW{1'b0}};
      if (state_next == S_RUN)
         fref_next = (below_set && act_units == `DRS_ACT_RUN_LIMIT) ? low_limit_reg : set_freq_reg;
      zero_out = (state_next == S_RUN) && open_loop && (fref_next == {FW{1'b0}});
      en_next  = (state_next == S_SBST) || (state_next == S_RUN) || (state_next == S_SBSP) ||
                 (state_next == S_DCBR) || ((state_next == S_STOP) && !coast_nx);
      dc_next  = (state_next == S_DCBR);
      if (zero_out) begin
         en_next = (zero_sel_reg != `DRS_ZERO_NO_OUT);
         dc_next = (zero_sel_reg == `DRS_ZERO_DC_OUT);
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         state_reg      <= S_IDLE;
         prev_state_reg <= S_IDLE;
         kind_reg       <= K_CMD;
         powerup_reg    <= 1'b1;
         drv_enable     <= 1'b0;
         ramp_down      <= 1'b0;
         short_brake    <= 1'b0;
         dc_brake       <= 1'b0;
         freq_ref       <= {FW{1'b0}};
         sb_current     <= 11'h000;
         run_active     <= 1'b0;
      end else begin
         state_reg      <= state_next;
         prev_state_reg <= state_reg;
         kind_reg       <= kind_next;
         if (state_reg != S_IDLE)
            powerup_reg <= 1'b0;
         drv_enable     <= en_next;
         ramp_down      <= (state_next == S_STOP) && !coast_nx;
         short_brake    <= (state_next == S_SBST) || (state_next == S_SBSP);
         dc_brake       <= dc_next;
         freq_ref       <= fref_next;
         sb_current     <= sb_curr_reg;
         run_active     <= (state_next == S_RUN);
      end
   end
endmodule // drs_run_seq
`default_nettype wire

// file: drs_map.vh
// register offsets, reset values and timing constants of the run/sleep sequencer
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

// clock and tick
`define DRS_CLK_HZ          25000000
`define DRS_TICK_MS         100
`define DRS_TICK_CYCLES     (`DRS_CLK_HZ / 1000 * `DRS_TICK_MS)

// register byte offsets
`define DRS_OFS_CTRL        8'h00
`define DRS_OFS_ACTION      8'h04
`define DRS_OFS_WAKE_DLY    8'h08
`define DRS_OFS_AUTO_RST    8'h0C
`define DRS_OFS_RST_WAIT    8'h10
`define DRS_OFS_START_DLY   8'h14
`define DRS_OFS_ZERO_SEL    8'h18
`define DRS_OFS_SB_CURR     8'h1C
`define DRS_OFS_SB_START    8'h20
`define DRS_OFS_SB_STOP     8'h24
`define DRS_OFS_START_MODE  8'h28
`define DRS_OFS_DC_TIME     8'h2C
`define DRS_OFS_DEMAG       8'h30
`define DRS_OFS_SET_FREQ    8'h34
`define DRS_OFS_LOW_LIMIT   8'h38
`define DRS_OFS_SLEEP_DLY   8'h3C
`define DRS_OFS_STATUS      8'h40

// field positions
`define DRS_CTRL_RUN        0
`define DRS_CTRL_OPEN_LOOP  1
`define DRS_ACT_UNITS_LSB   0
`define DRS_ACT_TENS_LSB    4

// field codes
`define DRS_ACT_RUN_LIMIT   4'h0
`define DRS_ACT_STOP        4'h1
`define DRS_ACT_SLEEP       4'h2
`define DRS_TENS_RAMP       4'h1
`define DRS_ZERO_NO_OUT     2'h0
`define DRS_ZERO_DC_OUT     2'h2
`define DRS_MODE_DIRECT     2'h0

// reset values (times in 0.1 s ticks, current in 0.1 %)
`define DRS_RST_CTRL        2'h0
`define DRS_RST_ACTION      8'h00
`define DRS_RST_WAKE_DLY    16'h0000
`define DRS_RST_AUTO_RST    1'h0
`define DRS_RST_RST_WAIT    16'h000A
`define DRS_RST_START_DLY   16'h0000
`define DRS_RST_ZERO_SEL    2'h0
`define DRS_RST_SB_CURR     11'h000
`define DRS_RST_SB_START    16'h0000
`define DRS_RST_SB_STOP     16'h0000
`define DRS_RST_START_MODE  2'h0
`define DRS_RST_DC_TIME     16'h0000
`define DRS_RST_DEMAG       16'h0000
`define DRS_RST_SET_FREQ    16'h0000
`define DRS_RST_LOW_LIMIT   16'h0000
`define DRS_RST_SLEEP_DLY   16'h0000

// short brake current ceiling, 150.0 %
`define DRS_SB_CURR_MAX     11'h5DC

`endif

// file: drs_tick.v
// divider producing the one-cycle 0.1 s tick enable
`default_nettype none
module drs_tick #(
   parameter CYCLES = 2500000
) (
   input  wire        mclk,
   input  wire        rst_n,
   output reg         tick
);
   reg  [31:0] cnt_reg;

   always @(posedge mclk) begin
      if (!rst_n) begin
         cnt_reg <= 32'h0000_0000;
         tick    <= 1'b0;
      end else if (cnt_reg >= CYCLES - 1) begin
         cnt_reg <= 32'h0000_0000;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         tick    <= 1'b0;
      end
   end
endmodule // drs_tick
`default_nettype wire

// file: drs_timer.v
// tick-counting phase timer, restarts whenever its enable drops
`default_nettype none
module drs_timer #(
   parameter W = 16
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire         tick,
   input  wire         en,
   input  wire [W-1:0] preset,
   output reg          done
);
   reg  [W-1:0] cnt_reg;

   always @(posedge mclk) begin
      if (!rst_n || !en) begin
         cnt_reg <= {W{1'b0}};
         done    <= 1'b0;
      end else if (cnt_reg >= preset) begin
         done    <= 1'b1;
      end else if (tick) begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // drs_timer
`default_nettype wire

// file: drs_run_seq_sva.sv
// concurrent checks on the sequencer's bus and power stage ports
`default_nettype none
module drs_run_seq_sva #(
   parameter FW = 16
) (
   input wire logic          mclk,
   input wire logic          rst_n,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest,
   input wire logic          drv_enable,
   input wire logic          ramp_down,
   input wire logic          short_brake,
   input wire logic          dc_brake,
   input wire logic [FW-1:0] freq_ref,
   input wire logic [10:0]   sb_current,
   input wire logic          run_active
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic req;
   assign req = avs_read || avs_write;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_ack_next: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_ack_cause: assert property (!req && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   a_rdata_hold: assert property (!req && avs_waitrequest |=> $stable(avs_readdata))
      else $error("read data moved between accesses");
   a_sb_limit: assert property (sb_current <= 11'h5dc)
      else $error("short brake current above ceiling");
   a_brake_excl: assert property (!(short_brake && dc_brake))
      else $error("short and dc braking together");
   a_run_clean: assert property (run_active |-> !short_brake && !ramp_down)
      else $error("braking or ramp while running");
   a_demag_gap: assert property ($rose(dc_brake) && !run_active |-> !$past(drv_enable))
      else $error("dc braking without blocked output first");
   a_idle_ref: assert property (!run_active && !ramp_down && !drv_enable |-> freq_ref == '0)
      else $error("reference not zero while stopped");
   c_run: cover property ($rose(run_active));
   c_short: cover property ($rose(short_brake));
   c_dc: cover property ($rose(dc_brake));
endmodule // drs_run_seq_sva
`default_nettype wire

// file: drs_motor_model.sv
// power stage and motor stand-in: follows the reference, ramps down on request
`default_nettype none
module drs_motor_model (
   input  wire logic        mclk,
   input  wire logic        drv_enable,
   input  wire logic        ramp_down,
   input  wire logic [15:0] freq_ref,
   input  wire logic        ok_in,
   output var  logic [15:0] run_freq,
   output var  logic        stop_reached_pin,
   output var  logic        dc_bus_ok_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial run_freq = '0;
   // ramp of 10 per cycle keeps stops short but not instant
   always @(posedge mclk) begin
      if (!drv_enable)
         run_freq <= '0;
      else if (ramp_down)
         run_freq <= (run_freq > 16'h000a) ? run_freq - 16'h000a : '0;
      else
         run_freq <= freq_ref;
   end
   assign stop_reached_pin = ramp_down && run_freq == '0;
   assign dc_bus_ok_pin = ok_in;
endmodule // drs_motor_model
`default_nettype wire

// file: tb_drs_run_seq.sv
// self-checking bench of the run/sleep sequencer
`include "drs_map.vh"
`default_nettype none
module tb_drs_run_seq;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, ok = 0;
   logic [7:0]  avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, q;
   logic [15:0] run_freq, freq_ref;
   logic [10:0] sb_current;
   logic        avs_waitrequest, stop_reached_pin, dc_bus_ok_pin, drv_enable, ramp_down, short_brake, dc_brake;
   logic        run_active;
   logic [4:0]  mon;
   int          n_errors = 0, total_checks = 0, n;
   // address, write data, expected read back
   logic [71:0] rows [7] = '{{`DRS_OFS_SB_CURR, 32'h0000_0064, 32'h0000_0064},
      {`DRS_OFS_SB_CURR, 32'h0000_05dd, 32'h0000_05dc}, {`DRS_OFS_SB_CURR, 32'h0000_07ff, 32'h0000_05dc},
      {8'h44, 32'h0000_ffff, 32'h0000_0000}, {`DRS_OFS_WAKE_DLY, 32'h0000_0005, 32'h0000_0005},
      {`DRS_OFS_DC_TIME, 32'h0000_0002, 32'h0000_0002}, {`DRS_OFS_SB_STOP, 32'h0000_0001, 32'h0000_0001}};
   assign mon = {run_active, dc_brake, short_brake, ramp_down, drv_enable};
   always #20 mclk = ~mclk;
   drs_run_seq #(.TICK_CYCLES(10), .FW(16)) u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_freq(run_freq),
      .stop_reached_pin(stop_reached_pin), .dc_bus_ok_pin(dc_bus_ok_pin), .drv_enable(drv_enable),
      .ramp_down(ramp_down), .short_brake(short_brake), .dc_brake(dc_brake), .freq_ref(freq_ref),
      .sb_current(sb_current), .run_active(run_active));
   drs_motor_model u_motor (.mclk(mclk), .drv_enable(drv_enable), .ramp_down(ramp_down), .freq_ref(freq_ref),
      .ok_in(ok), .run_freq(run_freq), .stop_reached_pin(stop_reached_pin), .dc_bus_ok_pin(dc_bus_ok_pin));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
      end
   endtask
   // request held until waitrequest seen low, then released one edge before the next
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(k < 100, 1'b1);
      @(posedge mclk);
   endtask
   // bit of mon: 0 enable, 1 ramp, 2 short, 3 dc, 4 run
   task automatic wt(input int b, input logic v);
      n = 0;
      while (mon[b] !== v && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 3000, 1'b1);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      results;
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk({avs_waitrequest, mon}, 6'h20);
      foreach (rows[i]) begin
         bus(1'b1, rows[i][71:64], rows[i][63:32]);
         bus(1'b0, rows[i][71:64], '0);
         chk(q, rows[i][31:0]);
      end
      chk(sb_current, 32'h0000_05dc);
      bus(1'b0, `DRS_OFS_RST_WAIT, '0);
      chk(q, 32'h0000_000a);
      chk(run_active, 1'b0);
      bus(1'b1, `DRS_OFS_RST_WAIT, 32'h0000_0003);
      bus(1'b1, `DRS_OFS_AUTO_RST, 32'h0000_0001);
      repeat (60) @(posedge mclk);
      chk(run_active, 1'b0);
      ok <= 1'b1;
      wt(4, 1'b1);
      chk(n <= 20, 1'b1);
      bus(1'b1, `DRS_OFS_CTRL, '0);
      wt(3, 1'b1);
      wt(3, 1'b0);
      // two ticks of dc braking; the first tick may land anywhere in its period
      chk(n >= 14 && n <= 23, 1'b1);
      bus(1'b1, `DRS_OFS_SB_START, 32'h0000_0002);
      bus(1'b1, `DRS_OFS_START_DLY, 32'h0000_0003);
      bus(1'b1, `DRS_OFS_CTRL, 32'h0000_0001);
      wt(2, 1'b1);
      chk(n >= 20 && n <= 45, 1'b1);
      wt(4, 1'b1);
      chk(n >= 10 && n <= 35, 1'b1);
      bus(1'b1, `DRS_OFS_SB_START, '0);
      bus(1'b1, `DRS_OFS_START_DLY, '0);
      bus(1'b1, `DRS_OFS_LOW_LIMIT, 32'h0000_0064);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_0032);
      repeat (10) @(posedge mclk);
      chk(freq_ref, 16'h0064);
      bus(1'b1, `DRS_OFS_ACTION, 32'h0000_0011);
      wt(1, 1'b1);
      wt(2, 1'b1);
      wt(3, 1'b1);
      wt(3, 1'b0);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_00c8);
      wt(4, 1'b1);
      chk(n <= 20, 1'b1);
      bus(1'b1, `DRS_OFS_ACTION, 32'h0000_0001);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_0032);
      wt(4, 1'b0);
      repeat (5) @(posedge mclk);
      chk({ramp_down, short_brake, drv_enable}, 3'h0);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_00c8);
      wt(4, 1'b1);
      // one tick of sleep delay rides over the first cycle of a restart, when the motor still reads zero
      bus(1'b1, `DRS_OFS_SLEEP_DLY, 32'h0000_0001);
      bus(1'b1, `DRS_OFS_ACTION, 32'h0000_0012);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_0032);
      wt(4, 1'b0);
      repeat (100) @(posedge mclk);
      chk(drv_enable, 1'b0);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_00c8);
      repeat (20) @(posedge mclk);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_0032);
      repeat (60) @(posedge mclk);
      chk(run_active, 1'b0);
      bus(1'b1, `DRS_OFS_SET_FREQ, 32'h0000_00c8);
      wt(4, 1'b1);
      chk(n >= 35 && n <= 75, 1'b1);
      bus(1'b1, `DRS_OFS_ACTION, '0);
      bus(1'b1, `DRS_OFS_LOW_LIMIT, '0);
      bus(1'b1, `DRS_OFS_SET_FREQ, '0);
      bus(1'b1, `DRS_OFS_CTRL, 32'h0000_0003);
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, `DRS_OFS_ZERO_SEL, s);
         repeat (10) @(posedge mclk);
         chk({dc_brake, drv_enable}, {s == 2, s != 0});
      end
      results;
   end
endmodule // tb_drs_run_seq
bind drs_run_seq drs_run_seq_sva #(.FW(FW)) u_sva (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .drv_enable(drv_enable), .ramp_down(ramp_down), .short_brake(short_brake), .dc_brake(dc_brake),
   .freq_ref(freq_ref), .sb_current(sb_current), .run_active(run_active));
`default_nettype wire
